// ===== core/twe_slave_frontend.sv
// two-wire slave front end of a paged byte memory with id page
// ==========================================================
`timescale 1ns/100ps
`default_nettype none
module twe_slave_frontend #(
    parameter int PROG_CYCLES = twe_pkg::PROG_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // power-on detector
    input wire logic por_active,
    // two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // straps
    input wire logic write_protect,
    input wire logic select_bit_0,
    input wire logic select_bit_1,
    input wire logic select_bit_2,
    // reader field
    input wire logic rf_field_present,
    output logic field_detect_output,
    // status
    output logic prog_busy
);
    localparam int NSLOW = 6;
    localparam logic [twe_pkg::TIMER_W-1:0] PROG_LAST =
        twe_pkg::TIMER_W'(PROG_CYCLES - 1);
    localparam logic [twe_pkg::TIMER_W-1:0] TIMER_STEP =
        twe_pkg::TIMER_W'(1);

    twe_pkg::twe_state_type state;
    twe_pkg::twe_phase_type phase;
    logic [2:0] scl_pipe;
    logic [2:0] sda_pipe;
    logic scl_f, sda_f, scl_d, sda_d;
    logic [NSLOW-1:0] slow_raw, slow_s1, slow_s2;
    logic por_hold, wp_sync, rf_sync;
    logic [2:0] sel_bits;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    logic [7:0] shreg;
    logic [3:0] bit_cnt;
    logic [twe_pkg::ADDR_W-1:0] addr_ptr;
    logic id_target, rw_read, master_ack, wr_pending, lock_req, id_lock;
    logic data_ok;
    logic buf_we;
    logic [twe_pkg::PAGE_W-1:0] buf_waddr;
    logic [7:0] buf_wdata, buf_rdata, arr_rdata, id_rdata, rd_byte;
    logic [twe_pkg::PAGE_BYTES-1:0] page_valid;
    logic [twe_pkg::TIMER_W-1:0] prog_cnt;
    logic [twe_pkg::PAGE_W-1:0] copy_idx, copy_d;
    logic walk_on, copy_vld, prog_done;

    // ==========================================================
    // input synchronisers
    assign slow_raw = {por_active, write_protect, select_bit_2,
                       select_bit_1, select_bit_0, rf_field_present};
    generate
        for (genvar i = 0; i < NSLOW; i++) begin : g_sync
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    slow_s1[i] <= 1'b0;
                    slow_s2[i] <= 1'b0;
                end else if (clk_en) begin
                    slow_s1[i] <= slow_raw[i];
                    slow_s2[i] <= slow_s1[i];
                end
            end
        end
    endgenerate
    assign por_hold = slow_s2[5];
    assign wp_sync = slow_s2[4];
    assign sel_bits = slow_s2[3:1];
    assign rf_sync = slow_s2[0];

    // bus lines: two flops, then a glitch filter on the third stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_pipe <= 3'h7;
            sda_pipe <= 3'h7;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else if (clk_en) begin
            scl_pipe <= {scl_pipe[1:0], scl_in};
            sda_pipe <= {sda_pipe[1:0], sda_in};
            if (scl_pipe[2] == scl_pipe[1]) begin
                scl_f <= scl_pipe[2];
            end
            if (sda_pipe[2] == sda_pipe[1]) begin
                sda_f <= sda_pipe[2];
            end
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end
    assign scl_rise = scl_f & ~scl_d;
    assign scl_fall = ~scl_f & scl_d;
    assign bus_start = scl_f & scl_d & sda_d & ~sda_f;
    assign bus_stop = scl_f & scl_d & ~sda_d & sda_f;

    // ==========================================================
    // byte sequencing
    assign rd_byte = id_target ? id_rdata : arr_rdata;
    // id page lock bit guards the id page; strap guards the array
    assign data_ok = id_target ? ~id_lock : ~wp_sync;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= twe_pkg::ST_IDLE;
            phase <= twe_pkg::PH_DEV;
            shreg <= 8'h00;
            bit_cnt <= 4'h0;
            addr_ptr <= 16'h0000;
            id_target <= 1'b0;
            rw_read <= 1'b0;
            master_ack <= 1'b0;
            wr_pending <= 1'b0;
            lock_req <= 1'b0;
            sda_oe <= 1'b0;
            buf_we <= 1'b0;
            buf_waddr <= 7'h00;
            buf_wdata <= 8'h00;
        end else if (clk_en) begin
            buf_we <= 1'b0;
            if (por_hold) begin
                state <= twe_pkg::ST_IDLE;
                sda_oe <= 1'b0;
                wr_pending <= 1'b0;
                lock_req <= 1'b0;
            end else if (state == twe_pkg::ST_PROGRAM) begin
                // bus is deaf until the cycle ends, so polls get no ack
                if (prog_done) begin
                    state <= twe_pkg::ST_IDLE;
                    wr_pending <= 1'b0;
                    lock_req <= 1'b0;
                end
            end else if (bus_start) begin
                state <= twe_pkg::ST_RX;
                phase <= twe_pkg::PH_DEV;
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
            end else if (bus_stop) begin
                sda_oe <= 1'b0;
                state <= wr_pending ? twe_pkg::ST_PROGRAM
                                    : twe_pkg::ST_IDLE;
            end else begin
                unique case (state)
                    twe_pkg::ST_IDLE: begin
                    end
                    twe_pkg::ST_RX: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], sda_f};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall &&
                                     bit_cnt == twe_pkg::BYTE_BITS) begin
                            unique case (phase)
                                twe_pkg::PH_DEV: begin
                                    if ((shreg[7:4] == twe_pkg::TYPE_MEM ||
                                         shreg[7:4] == twe_pkg::TYPE_ID) &&
                                        shreg[3:1] == sel_bits) begin
                                        id_target <= shreg[7:4] ==
                                                     twe_pkg::TYPE_ID;
                                        rw_read <= shreg[0];
                                        phase <= twe_pkg::PH_AHI;
                                        sda_oe <= 1'b1;
                                        state <= twe_pkg::ST_ACK;
                                    end else begin
                                        state <= twe_pkg::ST_IDLE;
                                    end
                                end
                                twe_pkg::PH_AHI: begin
                                    addr_ptr[15:8] <= shreg;
                                    phase <= twe_pkg::PH_ALO;
                                    sda_oe <= 1'b1;
                                    state <= twe_pkg::ST_ACK;
                                end
                                twe_pkg::PH_ALO: begin
                                    addr_ptr[7:0] <= shreg;
                                    phase <= twe_pkg::PH_DATA;
                                    sda_oe <= 1'b1;
                                    state <= twe_pkg::ST_ACK;
                                end
                                twe_pkg::PH_DATA: begin
                                    if (!data_ok) begin
                                        state <= twe_pkg::ST_IDLE;
                                    end else if (id_target &&
                                        addr_ptr[twe_pkg::ID_LOCK_BIT]) begin
                                        if (shreg[twe_pkg::LOCK_DATA_BIT]) begin
                                            lock_req <= 1'b1;
                                            wr_pending <= 1'b1;
                                        end
                                        sda_oe <= 1'b1;
                                        state <= twe_pkg::ST_ACK;
                                    end else begin
                                        buf_we <= 1'b1;
                                        buf_waddr <= addr_ptr[6:0];
                                        buf_wdata <= shreg;
                                        addr_ptr[6:0] <= addr_ptr[6:0] +
                                            twe_pkg::PAGE_STEP;
                                        wr_pending <= 1'b1;
                                        sda_oe <= 1'b1;
                                        state <= twe_pkg::ST_ACK;
                                    end
                                end
                            endcase
                        end
                    end
                    twe_pkg::ST_ACK: begin
                        if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            sda_oe <= 1'b0;
                            state <= twe_pkg::ST_RX;
                            if (rw_read) begin
                                shreg <= rd_byte;
                                sda_oe <= ~rd_byte[7];
                                bit_cnt <= 4'h1;
                                state <= twe_pkg::ST_TX;
                            end
                        end
                    end
                    twe_pkg::ST_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt == twe_pkg::BYTE_BITS) begin
                                sda_oe <= 1'b0;
                                state <= twe_pkg::ST_MACK;
                            end else begin
                                sda_oe <= ~shreg[6];
                                shreg <= {shreg[6:0], 1'b0};
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    twe_pkg::ST_MACK: begin
                        if (scl_rise) begin
                            master_ack <= ~sda_f;
                            if (!sda_f && id_target) begin
                                addr_ptr[5:0] <= addr_ptr[5:0] +
                                                 twe_pkg::ID_STEP;
                            end else if (!sda_f) begin
                                addr_ptr <= addr_ptr + twe_pkg::ADDR_STEP;
                            end
                        end else if (scl_fall) begin
                            if (master_ack) begin
                                shreg <= rd_byte;
                                sda_oe <= ~rd_byte[7];
                                bit_cnt <= 4'h1;
                                state <= twe_pkg::ST_TX;
                            end else begin
                                state <= twe_pkg::ST_IDLE;
                            end
                        end
                    end
                    twe_pkg::ST_PROGRAM: begin
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // page buffer bookkeeping: only received bytes get programmed
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            page_valid <= '0;
        end else if (clk_en) begin
            if (por_hold || prog_done) begin
                page_valid <= '0;
            end else if (buf_we) begin
                page_valid[buf_waddr] <= 1'b1;
            end
        end
    end

    // ==========================================================
    // self-timed programming: walk the buffer while the timer runs, then wait out the timer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prog_cnt <= '0;
            copy_idx <= 7'h00;
            copy_d <= 7'h00;
            walk_on <= 1'b0;
            copy_vld <= 1'b0;
        end else if (clk_en) begin
            if (state != twe_pkg::ST_PROGRAM || por_hold) begin
                prog_cnt <= '0;
                copy_idx <= 7'h00;
                walk_on <= 1'b1;
                copy_vld <= 1'b0;
            end else begin
                if (prog_cnt != PROG_LAST) begin
                    prog_cnt <= prog_cnt + TIMER_STEP;
                end
                copy_vld <= walk_on & page_valid[copy_idx];
                copy_d <= copy_idx;
                if (walk_on) begin
                    copy_idx <= copy_idx + twe_pkg::PAGE_STEP;
                    walk_on <= copy_idx != twe_pkg::PAGE_LAST;
                end
            end
        end
    end
    assign prog_done = state == twe_pkg::ST_PROGRAM && !por_hold &&
                       prog_cnt == PROG_LAST && !walk_on && !copy_vld;

    // lock is one-way: only a system reset clears it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            id_lock <= 1'b0;
        end else if (clk_en && prog_done && lock_req) begin
            id_lock <= 1'b1;
        end
    end

    // ==========================================================
    // outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sda_out <= 1'b0;
            field_detect_output <= 1'b0;
            prog_busy <= 1'b0;
        end else if (clk_en) begin
            sda_out <= 1'b0;
            field_detect_output <= rf_sync;
            prog_busy <= state == twe_pkg::ST_PROGRAM;
        end
    end

    // ==========================================================
    // storage
    twe_mem #(.ADDR_W(twe_pkg::PAGE_W), .WIDTH(8)) u_pagebuf (
        .clk(clk),
        .clk_en(clk_en),
        .wr_en(buf_we),
        .wr_addr(buf_waddr),
        .wr_data(buf_wdata),
        .rd_addr(copy_idx),
        .rd_data(buf_rdata)
    );
    twe_mem #(.ADDR_W(twe_pkg::ADDR_W), .WIDTH(8)) u_array (
        .clk(clk),
        .clk_en(clk_en),
        .wr_en(copy_vld & ~id_target),
        .wr_addr({addr_ptr[15:7], copy_d}),
        .wr_data(buf_rdata),
        .rd_addr(addr_ptr),
        .rd_data(arr_rdata)
    );
    twe_mem #(.ADDR_W(twe_pkg::ID_W), .WIDTH(8)) u_idpage (
        .clk(clk),
        .clk_en(clk_en),
        .wr_en(copy_vld & id_target & ~id_lock),
        .wr_addr(copy_d[5:0]),
        .wr_data(buf_rdata),
        .rd_addr(addr_ptr[5:0]),
        .rd_data(id_rdata)
    );
endmodule
`default_nettype wire

// ===== core/twe_pkg.sv
// constants and types shared by the two-wire memory slave front end
`default_nettype none
package twe_pkg;
    // ==========================================================
    // bus framing
    localparam logic [3:0] TYPE_MEM = 4'ha;
    localparam logic [3:0] TYPE_ID = 4'hb;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int LOCK_DATA_BIT = 1;
    // ==========================================================
    // memory organisation
    localparam int ADDR_W = 16;
    localparam int PAGE_W = 7;
    localparam int ID_W = 6;
    localparam int ID_LOCK_BIT = 10;
    localparam int PAGE_BYTES = 128;
    localparam logic [6:0] PAGE_LAST = 7'h7f;
    localparam logic [6:0] PAGE_STEP = 7'h01;
    localparam logic [15:0] ADDR_STEP = 16'h0001;
    localparam logic [5:0] ID_STEP = 6'h01;
    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int WRITE_TIME_NS = 5000000;
    localparam int PROG_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int TIMER_W = 17;
    // ==========================================================
    // sequencing
    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_PROGRAM
    } twe_state_type;
    typedef enum logic [1:0] {
        PH_DEV, PH_AHI, PH_ALO, PH_DATA
    } twe_phase_type;
endpackage
`default_nettype wire

// ===== core/twe_mem.sv
// simple dual-port byte memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module twe_mem #(
    parameter int ADDR_W = 7,
    parameter int WIDTH = 8
) (
    // clock
    input wire logic clk,
    input wire logic clk_en,
    // write port
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // read port
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] cells [0:(1<<ADDR_W)-1];

    always_ff @(posedge clk) begin
        if (clk_en) begin
            if (wr_en) begin
                cells[wr_addr] <= wr_data;
            end
            rd_data <= cells[rd_addr];
        end
    end
endmodule
`default_nettype wire

// ===== sim/twe_slave_frontend_monitor.sv
// port assertions for the two-wire memory slave front end
`timescale 1ns/100ps
`default_nettype none
module twe_slave_monitor #(
    parameter int PROG_CYCLES = 200
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // power-on detector
    input wire logic por_active,
    // two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // straps
    input wire logic write_protect,
    input wire logic select_bit_0,
    input wire logic select_bit_1,
    input wire logic select_bit_2,
    // reader field
    input wire logic rf_field_present,
    input wire logic field_detect_output,
    // status
    input wire logic prog_busy
);
    // ==========================================================
    // helpers: busy length, abort flag, settle after reset
    int busy_len;
    logic aborted;
    logic [1:0] settle;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clk) begin
        busy_len <= prog_busy ? busy_len + 1 : 0;
    end
    // an aborted cycle ends early on purpose, so its length is exempt
    always_ff @(posedge clk) begin
        if (sys_rst || !prog_busy) aborted <= 1'b0;
        else if (por_active) aborted <= 1'b1;
    end
    always_ff @(posedge clk) begin
        if (sys_rst) settle <= 2'h0;
        else if (settle != 2'h3) settle <= settle + 2'h1;
    end
    // ==========================================================
    // assertions
    a_sda_pull_only:
        assert property (sda_out == 1'b0)
        else $error("serial data driven high");
    a_por_no_ack:
        assert property (por_active [*5] |-> !sda_oe)
        else $error("answer while power-on reset held");
    a_por_abort:
        assert property ($rose(por_active) |-> ##[1:6] !prog_busy)
        else $error("programming not abandoned");
    a_field_delay:
        assert property (settle == 2'h3 |->
            field_detect_output == $past(rf_field_present, 3))
        else $error("field detect does not follow field");
    a_busy_length:
        assert property ($fell(prog_busy) && !aborted |->
            busy_len >= PROG_CYCLES - 1 && busy_len <= PROG_CYCLES + 1)
        else $error("programming time wrong");
    a_busy_bound:
        assert property (busy_len <= PROG_CYCLES + 1)
        else $error("busy beyond write time");
    a_silent_busy:
        assert property (prog_busy |-> !sda_oe)
        else $error("answer during programming");
    a_reset_quiet:
        assert property ($fell(sys_rst) |-> !prog_busy [*8])
        else $error("write started by reset");
    a_por_release:
        assert property ($fell(por_active) |-> !prog_busy [*8])
        else $error("write started by power-up");
endmodule
bind twe_slave_frontend twe_slave_monitor #(
    .PROG_CYCLES(PROG_CYCLES)
) twe_slave_monitor_i (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .por_active(por_active), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .write_protect(write_protect),
    .select_bit_0(select_bit_0), .select_bit_1(select_bit_1),
    .select_bit_2(select_bit_2), .rf_field_present(rf_field_present),
    .field_detect_output(field_detect_output), .prog_busy(prog_busy)
);
`default_nettype wire

// ===== sim/twe_bus_master.sv
// behavioural two-wire bus master facing the slave front end
`timescale 1ns/100ps
`default_nettype none
module twe_bus_master (
    // clock
    input wire logic clk,
    // two-wire bus
    input wire logic sda,
    output logic scl,
    output logic master_oe
);
    // ==========================================================
    // clock idles high between frames, data left to the pull-up
    initial begin
        scl = 1'b1;
        master_oe = 1'b0;
    end
    // data moves only while the clock is low, sampled late in high
    task automatic bit_c(input logic b, output logic s);
        @(posedge clk) master_oe <= !b;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (3) @(posedge clk);
        s = sda;
        scl <= 1'b0;
    endtask
    // serves as repeated start too: clock up with data free
    task automatic start_c();
        @(posedge clk) master_oe <= 1'b0;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        master_oe <= 1'b1;
        repeat (4) @(posedge clk);
        scl <= 1'b0;
    endtask
    task automatic stop_c();
        @(posedge clk) master_oe <= 1'b1;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        master_oe <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // eight bits msb first, then the answer slot
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) bit_c(tx[i], rx[i]);
    endtask
endmodule
`default_nettype wire

// ===== sim/test_two_wire_eeprom_slave_frontend.sv
// self-checking bench for the two-wire memory slave front end
`timescale 1ns/100ps
`default_nettype none
module test_two_wire_eeprom_slave_frontend;
    // ==========================================================
    // signals and reference data
    localparam int PROG = 200;
    logic clk, sys_rst, por_active, write_protect, rf_field_present;
    logic sda_out, sda_oe, field_detect_output, prog_busy, scl, m_oe;
    logic [2:0] sel, rf_hist;
    logic [7:0] ref_mem [int];
    logic [7:0] ref_id [int];
    integer seed = 32'h7cdb;
    int miscompares = 0, checks_done = 0;
    wire logic sda_line = !(sda_oe || m_oe);
    twe_slave_frontend #(.PROG_CYCLES(PROG)) twe_slave_frontend_i (
        .clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
        .por_active(por_active), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe),
        .write_protect(write_protect), .select_bit_0(sel[0]),
        .select_bit_1(sel[1]), .select_bit_2(sel[2]),
        .rf_field_present(rf_field_present),
        .field_detect_output(field_detect_output), .prog_busy(prog_busy)
    );
    twe_bus_master twe_bus_master_i (
        .clk(clk), .sda(sda_line), .scl(scl), .master_oe(m_oe)
    );
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        rf_field_present <= sys_rst ? 1'b0 : 1'($random(seed));
        rf_hist <= {rf_hist[1:0], rf_field_present};
    end
    // ==========================================================
    // helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h, expected %h",
                $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] ident(input logic [3:0] ty, input logic rd);
        return {ty, sel, rd};
    endfunction
    // only the in-page bits advance while writing
    function automatic logic [15:0] pnext(input logic [15:0] a);
        return {a[15:7], a[6:0] + 7'h01};
    endfunction
    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic [8:0] rx;
        twe_bus_master_i.xfer({b, 1'b1}, rx);
        check(rx[0], !exp_ack);
    endtask
    task automatic probe(input logic [7:0] id, input logic exp_ack);
        twe_bus_master_i.start_c();
        send(id, exp_ack);
        twe_bus_master_i.stop_c();
    endtask
    task automatic wait_idle();
        for (int i = 0; i < PROG + 300 && prog_busy !== 1'b0; i++)
            @(posedge clk);
        check(prog_busy, 1'b0);
        check(field_detect_output, rf_hist[2]);
    endtask
    task automatic write_frame(input logic [3:0] ty, input logic [15:0] a,
            input int n, input logic [7:0] d0, input logic ok);
        logic [7:0] d;
        logic mem;
        mem = (ty == twe_pkg::TYPE_MEM);
        twe_bus_master_i.start_c();
        send(ident(ty, 1'b0), 1'b1);
        send(a[15:8], 1'b1);
        send(a[7:0], 1'b1);
        for (int i = 0; i < n; i++) begin
            d = (i == 0) ? d0 : 8'($random(seed));
            send(d, ok);
            if (ok && mem) ref_mem[a] = d;
            if (ok && !mem && !a[10]) ref_id[a[5:0]] = d;
            a = pnext(a);
        end
        twe_bus_master_i.stop_c();
        repeat (4) @(posedge clk);
        if (mem) check(prog_busy, ok && n > 0);
        if (mem && ok && n > 0) probe(ident(ty, 1'b0), 1'b0);
        wait_idle();
    endtask
    task automatic read_frame(input logic [3:0] ty, input logic [15:0] a,
            input int n);
        logic [8:0] rx;
        twe_bus_master_i.start_c();
        send(ident(ty, 1'b0), 1'b1);
        send(a[15:8], 1'b1);
        send(a[7:0], 1'b1);
        twe_bus_master_i.start_c();
        send(ident(ty, 1'b1), 1'b1);
        for (int i = 0; i < n; i++) begin
            twe_bus_master_i.xfer({8'hff, i == n - 1}, rx);
            if (ty == twe_pkg::TYPE_ID) check(rx[8:1], ref_id[a[5:0]]);
            else check(rx[8:1], ref_mem[a]);
            a = a + 16'h0001;
        end
        twe_bus_master_i.stop_c();
    endtask
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // a hung handshake must not stall the run
    initial begin
        repeat (90000) @(posedge clk);
        miscompares++;
        complete_run();
    end
    // ==========================================================
    // tests
    initial begin
        logic [15:0] base, a;
        int n;
        sys_rst = 1'b1;
        por_active = 1'b1;
        write_protect = 1'b0;
        sel = 3'h0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        sel <= 3'($random(seed));
        repeat (4) @(posedge clk);
        probe(ident(twe_pkg::TYPE_MEM, 1'b0), 1'b0);
        por_active <= 1'b0;
        repeat (10) @(posedge clk);
        $display("test power-up done");
        for (int k = 0; k < 8; k++)
            probe({twe_pkg::TYPE_MEM, 3'(k), 1'b0}, 3'(k) == sel);
        probe({4'h5, sel, 1'b0}, 1'b0);
        $display("test addressing done");
        base = {9'($random(seed)), 7'h00};
        write_frame(twe_pkg::TYPE_MEM, base, 0, 8'h00, 1'b1);
        probe(ident(twe_pkg::TYPE_MEM, 1'b0), 1'b1);
        for (int j = 0; j < 6; j++) begin
            a = base | 16'(7'h7c + 7'($random(seed) & 3));
            n = 1 + ($random(seed) & 3);
            write_frame(twe_pkg::TYPE_MEM, a, n, 8'($random(seed)), 1);
            for (int i = 0; i < n; i++) begin
                read_frame(twe_pkg::TYPE_MEM, a, 1);
                a = pnext(a);
            end
        end
        write_frame(twe_pkg::TYPE_MEM, base + 16'h0080, 1, 8'h3c, 1);
        write_frame(twe_pkg::TYPE_MEM, base | 16'h007f, 1, 8'hc3, 1);
        read_frame(twe_pkg::TYPE_MEM, base | 16'h007f, 2);
        $display("test page write done");
        write_protect <= 1'b1;
        write_frame(twe_pkg::TYPE_MEM, base | 16'h007f, 1, 8'h5a, 0);
        read_frame(twe_pkg::TYPE_MEM, base | 16'h007f, 1);
        write_protect <= 1'b0;
        $display("test write protect done");
        write_frame(twe_pkg::TYPE_ID, 16'h0003, 3, 8'h96, 1);
        read_frame(twe_pkg::TYPE_ID, 16'h0003, 3);
        write_frame(twe_pkg::TYPE_ID, 16'h0400, 1, 8'h02, 1);
        write_frame(twe_pkg::TYPE_ID, 16'h0003, 1, 8'h69, 0);
        read_frame(twe_pkg::TYPE_ID, 16'h0003, 1);
        $display("test id page done");
        a = base + 16'h0100;
        twe_bus_master_i.start_c();
        send(ident(twe_pkg::TYPE_MEM, 1'b0), 1'b1);
        send(a[15:8], 1'b1);
        send(a[7:0], 1'b1);
        send(8'ha5, 1'b1);
        twe_bus_master_i.stop_c();
        repeat (20) @(posedge clk);
        por_active <= 1'b1;
        repeat (8) @(posedge clk);
        check(prog_busy, 1'b0);
        probe(ident(twe_pkg::TYPE_MEM, 1'b0), 1'b0);
        por_active <= 1'b0;
        repeat (10) @(posedge clk);
        probe(ident(twe_pkg::TYPE_MEM, 1'b0), 1'b1);
        $display("test power-down done");
        complete_run();
    end
endmodule
`default_nettype wire
